// >>> hdl/dct_pkg.sv
package dct_pkg;

  // ==========================================================================
  // Register map (word offsets on the Wishbone bus, byte addresses)
  // ==========================================================================
  localparam logic [7:0] DCT_OFF_MODE   = 8'h00; // timer_mode_register
  localparam logic [7:0] DCT_OFF_CTRL   = 8'h04; // timer_control_register
  localparam logic [7:0] DCT_OFF_CKSEL  = 8'h08; // clock_select_register
  localparam logic [7:0] DCT_OFF_GCFG   = 8'h0C; // gate_input_config_register
  localparam logic [7:0] DCT_OFF_CNT_A  = 8'h10; // count bytes of timer A
  localparam logic [7:0] DCT_OFF_CNT_B  = 8'h14; // count bytes of timer B

  // ==========================================================================
  // Field positions
  // ==========================================================================
  // Mode register: per timer a nibble, timer A in [3:0], timer B in [7:4]
  localparam int DCT_MODE_M0     = 0; // mode select: 0 = 13 bit, 1 = 16 bit
  localparam int DCT_MODE_EXT    = 2; // external_count_select
  localparam int DCT_MODE_GATE   = 3; // gate_control
  localparam int DCT_MODE_B_BASE = 4; // nibble offset of timer B
  // Control register
  localparam int DCT_CTRL_RUN_A  = 4; // run_bit_a
  localparam int DCT_CTRL_RUN_B  = 6; // run_bit_b
  localparam int DCT_CTRL_OVF_A  = 5; // overflow flag A
  localparam int DCT_CTRL_OVF_B  = 7; // overflow flag B
  // Clock select register
  localparam int DCT_CK_SCALE_LO = 0; // clock scale bits [1:0]
  localparam int DCT_CK_DIR_A    = 3; // direct_clock_select_a
  localparam int DCT_CK_DIR_B    = 4; // direct_clock_select_b
  // Gate config register
  localparam int DCT_GC_POL_A    = 3; // gate_polarity_a
  localparam int DCT_GC_POL_B    = 7; // gate_polarity_b

  // ==========================================================================
  // Reset values and prescaler
  // ==========================================================================
  localparam logic [7:0]  DCT_RST_BYTE  = 8'h00;
  localparam logic [15:0] DCT_RST_COUNT = 16'h0000;
  localparam logic [5:0]  DCT_DIV_12    = 6'h0B; // Terminal count of /12
  localparam logic [5:0]  DCT_DIV_4     = 6'h03; // Terminal count of /4
  localparam logic [5:0]  DCT_DIV_48    = 6'h2F; // Terminal count of /48

  // Per-timer configuration carried as one struct
  typedef struct packed {
    logic       mode16;    // 16-bit mode
    logic       ext_sel;   // count falling edges of the pin
    logic       gate_ctl;  // gate by external input
    logic       direct;    // direct system clock
    logic       run;       // run bit
    logic       gate_pol;  // gate active level
  } dct_cfg_t;

  // Word written into a timer's count
  typedef struct packed {
    logic        we;
    logic [3:0]  sel;
    logic [15:0] data;
  } dct_load_t;

endpackage

// >>> hdl/dct_prescaler.sv
`timescale 1ns/100ps
// ============================================================================
// Prescaler: one-cycle tick at the scaled rate chosen by the scale bits
// ============================================================================
module dct_prescaler
  import dct_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] scale_i,  // 00 /12, 01 /4, 10 /48, 11 external tick
  input  wire logic       ext_tick_i, // Synchronous slow tick for scale 11
  output logic            tick_o
);

  logic [5:0] cnt_q;   // Divider count
  logic [5:0] cnt_d;
  logic       tick_q;  // Registered tick
  logic       tick_d;
  logic [5:0] term;    // Terminal count for the selected ratio

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    case (scale_i)
      2'b00:   term = DCT_DIV_12;
      2'b01:   term = DCT_DIV_4;
      2'b10:   term = DCT_DIV_48;
      default: term = DCT_DIV_12;
    endcase
    // Scale change mid-count may stretch one period; harmless for a timer
    if (cnt_q >= term) begin
      cnt_d = 6'h00;
    end else begin
      cnt_d = cnt_q + 6'h01;
    end
    if (scale_i == 2'b11) begin
      tick_d = ext_tick_i;
    end else begin
      tick_d = (cnt_q >= term);
    end
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

// >>> hdl/dct_timer.sv
`timescale 1ns/100ps
// ============================================================================
// One counter/timer channel with 13/16-bit count, pin edge and gating
// ============================================================================
module dct_timer
  import dct_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire dct_cfg_t  cfg_i,       // Configuration bits of this channel
  input  wire logic      prescale_i,  // Prescaler tick
  input  wire logic      pin_i,       // Synchronised count pin
  input  wire logic      gate_i,      // Synchronised gate input
  input  wire dct_load_t load_i,      // Software write to the count
  output logic [15:0]    count_o,
  output logic           ovf_o        // One-cycle wrap pulse
);

  logic [15:0] cnt_q;    // Count bytes, high in [15:8], low in [7:0]
  logic [15:0] cnt_d;
  logic        pin_q;    // Previous pin level for edge detect
  logic        ovf_q;
  logic        ovf_d;
  logic        enable;   // Run and gate condition
  logic        inc;      // Count this cycle
  logic [15:0] nxt;

  // ==========================================================================
  // Count logic
  // ==========================================================================
  always_comb begin
    // Run gates everything; gate input only matters with gate control set
    enable = cfg_i.run && (!cfg_i.gate_ctl || (gate_i == cfg_i.gate_pol));
    if (cfg_i.ext_sel) begin
      inc = enable && pin_q && !pin_i;
    end else if (cfg_i.direct) begin
      inc = enable;
    end else begin
      inc = enable && prescale_i;
    end
    nxt   = cnt_q;
    ovf_d = 1'b0;
    if (inc) begin
      if (cfg_i.mode16) begin
        nxt   = cnt_q + 16'h0001;
        ovf_d = (cnt_q == 16'hFFFF);
      end else begin
        // 13 bits: high byte above low five bits of the low byte
        nxt[4:0]  = cnt_q[4:0] + 5'h01;
        nxt[7:5]  = cnt_q[7:5];
        if (cnt_q[4:0] == 5'h1F) begin
          nxt[15:8] = cnt_q[15:8] + 8'h01;
        end
        ovf_d = (cnt_q[15:8] == 8'hFF) && (cnt_q[4:0] == 5'h1F);
      end
    end
    // Software load wins over counting; run bit never clears the count
    cnt_d = nxt;
    if (load_i.we && load_i.sel[0]) begin
      cnt_d[7:0] = load_i.data[7:0];
    end
    if (load_i.we && load_i.sel[1]) begin
      cnt_d[15:8] = load_i.data[15:8];
    end
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= DCT_RST_COUNT;
      pin_q <= 1'b1;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pin_q <= pin_i;
      ovf_q <= ovf_d;
    end
  end

  assign count_o = cnt_q;
  assign ovf_o   = ovf_q;

endmodule

// >>> hdl/dct_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Falling pin edges count when external select set
// - Else direct clock bit picks sysclk or prescaler
// - Count only when run and gate condition hold
// - Run low disables; inactive gate stops counting only with gate control set
// - Run bit never clears count; software preloads
// - Timer B identical, own bits, 13/16-bit count
// - Timer B gate uses own input and polarity
// - Sixteen-bit mode uses all count bits
module dct_top
  import dct_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Pins
  input  wire logic        count_input_pin_a_i,
  input  wire logic        count_input_pin_b_i,
  input  wire logic        gate_input_a_i,
  input  wire logic        gate_input_b_i,
  input  wire logic        ext_scale_tick_i    // Slow external tick, scale 11
);

  // ==========================================================================
  // Pin synchronisers (two flops each, second flop read only)
  // ==========================================================================
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic [4:0] pin_raw;

  assign pin_raw = {ext_scale_tick_i, gate_input_b_i, gate_input_a_i,
                    count_input_pin_b_i, count_input_pin_a_i};

  // Reset high so an idle-high pin does not fake a falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 5'h0F;
      pin_sync_q <= 5'h0F;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // External tick as a single pulse on its rising edge
  logic ext_prev_q;
  logic ext_pulse;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= pin_sync_q[4];
    end
  end
  assign ext_pulse = pin_sync_q[4] && !ext_prev_q;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] mode_q,  mode_d;    // timer_mode_register
  logic [7:0] ctrl_q,  ctrl_d;    // timer_control_register
  logic [7:0] cksel_q, cksel_d;   // clock_select_register
  logic [7:0] gcfg_q,  gcfg_d;    // gate_input_config_register
  logic       ack_q,   ack_d;
  logic       err_q,   err_d;
  logic [31:0] rdat_q, rdat_d;

  logic [15:0] count_a, count_b;  // Live counts
  logic        ovf_a,   ovf_b;    // Wrap pulses
  logic        req;               // New bus request this cycle
  logic        hit;               // Address is mapped
  logic        wr;                // Accepted write
  dct_cfg_t    cfg_a,   cfg_b;
  dct_load_t   load_a,  load_b;
  logic        tick;

  // Decodes an offset into a mapped flag, used by read and write paths
  function automatic logic dct_mapped(input logic [7:0] a);
    case (a)
      DCT_OFF_MODE, DCT_OFF_CTRL, DCT_OFF_CKSEL,
      DCT_OFF_GCFG, DCT_OFF_CNT_A, DCT_OFF_CNT_B: dct_mapped = 1'b1;
      default:                                     dct_mapped = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // Bus and control next-state logic
  // ==========================================================================
  always_comb begin
    // One wait-free answer cycle; ack drops the cycle after it is given
    req     = cyc_i && stb_i && !ack_q && !err_q;
    hit     = dct_mapped(adr_i);
    wr      = req && hit && we_i;
    ack_d   = req && hit;
    err_d   = req && !hit;
    mode_d  = mode_q;
    ctrl_d  = ctrl_q;
    cksel_d = cksel_q;
    gcfg_d  = gcfg_q;
    rdat_d  = rdat_q;
    if (wr && sel_i[0]) begin
      case (adr_i)
        DCT_OFF_MODE:  mode_d  = dat_i[7:0];
        DCT_OFF_CTRL:  ctrl_d  = dat_i[7:0];
        DCT_OFF_CKSEL: cksel_d = dat_i[7:0];
        DCT_OFF_GCFG:  gcfg_d  = dat_i[7:0];
        default:       mode_d  = mode_q;
      endcase
    end
    // Overflow flags: hardware set wins over a software clear
    if (ovf_a) begin
      ctrl_d[DCT_CTRL_OVF_A] = 1'b1;
    end
    if (ovf_b) begin
      ctrl_d[DCT_CTRL_OVF_B] = 1'b1;
    end
    if (req && hit && !we_i) begin
      case (adr_i)
        DCT_OFF_MODE:  rdat_d = {24'h00_0000, mode_q};
        DCT_OFF_CTRL:  rdat_d = {24'h00_0000, ctrl_q};
        DCT_OFF_CKSEL: rdat_d = {24'h00_0000, cksel_q};
        DCT_OFF_GCFG:  rdat_d = {24'h00_0000, gcfg_q};
        DCT_OFF_CNT_A: rdat_d = {16'h0000, count_a};
        DCT_OFF_CNT_B: rdat_d = {16'h0000, count_b};
        default:       rdat_d = 32'h0000_0000;
      endcase
    end else if (req) begin
      rdat_d = 32'h0000_0000;
    end
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q  <= DCT_RST_BYTE;
      ctrl_q  <= DCT_RST_BYTE;
      cksel_q <= DCT_RST_BYTE;
      gcfg_q  <= DCT_RST_BYTE;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end else begin
      mode_q  <= mode_d;
      ctrl_q  <= ctrl_d;
      cksel_q <= cksel_d;
      gcfg_q  <= gcfg_d;
      ack_q   <= ack_d;
      err_q   <= err_d;
      rdat_q  <= rdat_d;
    end
  end

  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = rdat_q;

  // ==========================================================================
  // Channel configuration
  // ==========================================================================
  always_comb begin
    cfg_a.mode16   = mode_q[DCT_MODE_M0];
    cfg_a.ext_sel  = mode_q[DCT_MODE_EXT];
    cfg_a.gate_ctl = mode_q[DCT_MODE_GATE];
    cfg_a.direct   = cksel_q[DCT_CK_DIR_A];
    cfg_a.run      = ctrl_q[DCT_CTRL_RUN_A];
    cfg_a.gate_pol = gcfg_q[DCT_GC_POL_A];
    // Timer B: same fields in its own nibble and own bits
    cfg_b.mode16   = mode_q[DCT_MODE_B_BASE + DCT_MODE_M0];
    cfg_b.ext_sel  = mode_q[DCT_MODE_B_BASE + DCT_MODE_EXT];
    cfg_b.gate_ctl = mode_q[DCT_MODE_B_BASE + DCT_MODE_GATE];
    cfg_b.direct   = cksel_q[DCT_CK_DIR_B];
    cfg_b.run      = ctrl_q[DCT_CTRL_RUN_B];
    cfg_b.gate_pol = gcfg_q[DCT_GC_POL_B];
    load_a.we      = wr && (adr_i == DCT_OFF_CNT_A);
    load_a.sel     = sel_i;
    load_a.data    = dat_i[15:0];
    load_b.we      = wr && (adr_i == DCT_OFF_CNT_B);
    load_b.sel     = sel_i;
    load_b.data    = dat_i[15:0];
  end

  // ==========================================================================
  // Shared prescaler and two channels
  // ==========================================================================
  dct_prescaler u_pre (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .scale_i    (cksel_q[DCT_CK_SCALE_LO +: 2]),
    .ext_tick_i (ext_pulse),
    .tick_o     (tick)
  );

  dct_timer u_tmr_a (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cfg_i      (cfg_a),
    .prescale_i (tick),
    .pin_i      (pin_sync_q[0]),
    .gate_i     (pin_sync_q[2]),
    .load_i     (load_a),
    .count_o    (count_a),
    .ovf_o      (ovf_a)
  );

  dct_timer u_tmr_b (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cfg_i      (cfg_b),
    .prescale_i (tick),
    .pin_i      (pin_sync_q[1]),
    .gate_i     (pin_sync_q[3]),
    .load_i     (load_b),
    .count_o    (count_b),
    .ovf_o      (ovf_b)
  );

endmodule

// >>> verification/dct_pins.sv
`timescale 1ns/100ps
// ============================================================
// Far side: count sources and gate levels, idle high as pulled up
module dct_pins (
  input  wire logic clk_i,
  output logic      count_a_o,
  output logic      count_b_o,
  output logic      gate_a_o,
  output logic      gate_b_o
);
  initial begin
    count_a_o = 1'b1;
    count_b_o = 1'b1;
    gate_a_o  = 1'b1;
    gate_b_o  = 1'b1;
  end
  // Each pulse is one falling edge; len sets prompt or slow phases
  task automatic pulse(input int b, input int n, input int len);
    for (int i = 0; i < n; i++) begin
      repeat (len) @(posedge clk_i);
      if (b == 0) count_a_o <= 1'b0;
      else count_b_o <= 1'b0;
      repeat (len) @(posedge clk_i);
      if (b == 0) count_a_o <= 1'b1;
      else count_b_o <= 1'b1;
    end
    // Margin for the synchroniser before anyone reads the count
    repeat (4) @(posedge clk_i);
  endtask
  task automatic gate(input int b, input logic lvl);
    if (b == 0) gate_a_o <= lvl;
    else gate_b_o <= lvl;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// >>> verification/dct_sva.sv
`timescale 1ns/100ps
// ============================================================
// Bus answer checks, seen only through the top-level ports
module dct_sva
  import dct_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  input  wire logic        err_o
);
  // Mapped offsets decide between ack and err
  function automatic logic mapped(input logic [7:0] a);
    return a inside {DCT_OFF_MODE, DCT_OFF_CTRL, DCT_OFF_CKSEL, DCT_OFF_GCFG, DCT_OFF_CNT_A, DCT_OFF_CNT_B};
  endfunction
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A fresh request, and its one-cycle answer
  sequence s_req;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_ans;
    ack_o || err_o;
  endsequence
  property p_answer;
    s_req |=> s_ans;
  endproperty
  property p_pulse;
    s_ans |=> !ack_o && !err_o;
  endproperty
  property p_cause;
    s_ans |-> $past(cyc_i && stb_i);
  endproperty
  property p_ackmap;
    ack_o |-> mapped($past(adr_i));
  endproperty
  property p_errmap;
    err_o |-> !mapped($past(adr_i));
  endproperty
  property p_zero;
    err_o || (ack_o && $past(we_i)) |-> dat_o == 32'h0000_0000;
  endproperty
  property p_upper;
    ack_o |-> dat_o[31:16] == 16'h0000;
  endproperty
  // Read data must not wander between answers
  property p_hold;
    !ack_o && !err_o |-> $stable(dat_o);
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered in one cycle");
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  a_cause: assert property (p_cause) else $error("answer without request");
  a_ackmap: assert property (p_ackmap) else $error("ack on unmapped offset");
  a_errmap: assert property (p_errmap) else $error("err on mapped offset");
  a_zero: assert property (p_zero) else $error("read data not zero on write or err");
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  a_hold: assert property (p_hold) else $error("read data changed between answers");
endmodule

// >>> verification/testbench.sv
`timescale 1ns/100ps
// ============================================================
// Self-checking bench: one task per scenario
module testbench;
  import dct_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, e;
  logic        pin_a, pin_b, gate_a, gate_b, tick_x;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  int          mismatches, comparisons;

  dct_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .count_input_pin_a_i(pin_a),
    .count_input_pin_b_i(pin_b), .gate_input_a_i(gate_a), .gate_input_b_i(gate_b), .ext_scale_tick_i(tick_x));
  dct_pins pins (.clk_i(clk_i), .count_a_o(pin_a), .count_b_o(pin_b), .gate_a_o(gate_a), .gate_b_o(gate_b));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ============================================================
  // Classic cycle: request stands until ack or err is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 40);
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 40) mismatches++;
    @(posedge clk_i);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, q, exp);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rchk("reset value", 8'(4 * i), 32'h0000_0000);
    bus(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
    $display("test reset done");
  endtask
  // Start and stop writes sit three cycles apart, so three counts
  task automatic t_wrap(input int b, input logic m);
    logic [7:0] cnt;
    cnt = DCT_OFF_CNT_A + 8'(4 * b);
    bus(1'b1, DCT_OFF_CKSEL, 32'h0000_0018);
    bus(1'b1, DCT_OFF_MODE, 32'(m) << (4 * b));
    bus(1'b1, cnt, 32'h0000_FFFE);
    bus(1'b1, DCT_OFF_CTRL, 32'h0000_0010 << (2 * b));
    // Stop writes zero, so only the hardware can have set the flag
    bus(1'b1, DCT_OFF_CTRL, 32'h0000_0000);
    rchk("wrap count", cnt, m ? 32'h0000_0001 : 32'h0000_00E1);
    rchk("overflow", DCT_OFF_CTRL, 32'h0000_0020 << (2 * b));
    bus(1'b1, DCT_OFF_CTRL, 32'h0000_0000);
    rchk("overflow clear", DCT_OFF_CTRL, 32'h0000_0000);
    $display("test wrap done");
  endtask
  task automatic t_ext(input int b);
    logic [7:0] cnt;
    logic       act;
    cnt = DCT_OFF_CNT_A + 8'(4 * b);
    act = (b == 0);
    bus(1'b1, DCT_OFF_GCFG, act ? 32'h0000_0008 : 32'h0000_0000);
    bus(1'b1, DCT_OFF_MODE, 32'h0000_000C << (4 * b));
    bus(1'b1, cnt, 32'h0000_0000);
    pins.gate(b, !act);
    bus(1'b1, DCT_OFF_CTRL, 32'h0000_0010 << (2 * b));
    pins.pulse(b, 3, 2);
    rchk("gate closed", cnt, 32'h0000_0000);
    pins.gate(b, act);
    pins.pulse(b, 5, 3);
    rchk("pin edges", cnt, 32'h0000_0005);
    bus(1'b1, DCT_OFF_MODE, 32'h0000_0004 << (4 * b));
    pins.gate(b, !act);
    pins.pulse(b, 2, 6);
    rchk("gate unused", cnt, 32'h0000_0007);
    bus(1'b1, DCT_OFF_CTRL, 32'h0000_0000);
    pins.pulse(b, 2, 2);
    rchk("run low", cnt, 32'h0000_0007);
    $display("test pins done");
  endtask
  // Prescaler phase is unknown, so one count either way is allowed
  task automatic t_scale();
    int div [3] = '{12, 4, 48};
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, DCT_OFF_CKSEL, 32'(s));
      bus(1'b1, DCT_OFF_MODE, 32'h0000_0001);
      bus(1'b1, DCT_OFF_CNT_A, 32'h0000_0000);
      bus(1'b1, DCT_OFF_CTRL, 32'h0000_0010);
      repeat (93) @(posedge clk_i);
      bus(1'b1, DCT_OFF_CTRL, 32'h0000_0000);
      bus(1'b0, DCT_OFF_CNT_A, 32'h0000_0000);
      chk("scaled count", 32'((q >= 96 / div[s] - 1) && (q <= 96 / div[s] + 1)), 32'h0000_0001);
    end
    // Scale 11: four slow rising edges on the external tick give four counts
    bus(1'b1, DCT_OFF_CKSEL, 32'h0000_0003);
    bus(1'b1, DCT_OFF_CNT_A, 32'h0000_0000);
    bus(1'b1, DCT_OFF_CTRL, 32'h0000_0010);
    for (int i = 0; i < 4; i++) begin
      tick_x <= 1'b1;
      repeat (3) @(posedge clk_i);
      tick_x <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    bus(1'b1, DCT_OFF_CTRL, 32'h0000_0000);
    rchk("external tick count", DCT_OFF_CNT_A, 32'h0000_0004);
    $display("test scale done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    tick_x = 1'b0;
    dat_i = 32'h0000_0000;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    for (int b = 0; b < 2; b++) begin
      t_wrap(b, 1'b0);
      t_wrap(b, 1'b1);
      t_ext(b);
    end
    t_scale();
    final_report();
  end
  // Watchdog well beyond the under one thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    final_report();
  end
endmodule

bind dct_top dct_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o));
